// ---- rtl/cycle_resize_manager.sv ----
// Operation
// - before start, peer packets still update heard map, cycle end, slot sync and halted-peer flag only
// - cycle end field resets to 63; other values mean resized cycle
// - slot timer readable in run config bits 0 to 6 always
// - with no peers the slot timer free-runs on local time base
// - heard map bits outside own span in public frames show active stations
// - accepted pending value sent four times, then pending clears to zero
// - pending writes ignored unless device is in the running phase
// - pending values below own span's last address are rejected
// - each station adopts a peer's new cycle end unless its own pending resize wins; done trigger raised if the value changes
// - simultaneous resizes: lowest station address wins
// - higher-priority resize while pending holds a value sets overlap flag
// - overlap flag cleared only by writing one
// - overlap trigger only on the flag's rise from zero
// - an overlap from a clear flag raises overlap and done triggers together when enabled
// - break phase entered if span exceeds cycle end at start, or after halt
// - break phase sends break packets in public frames
// - received break packet sets the halted-peer flag
// - writing one clears halted-peer flag; later breaks set it again
// - halted-peer trigger only on the flag's rise from zero
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "cycle_resize_params.svh"
module cycle_resize_manager #(
	parameter int SLOT_CYCLES = 32
) (
	input wire logic CLK_IN,
	input wire logic NRST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire logic RX_VALID_IN,
	input wire cycle_resize_pkg::pkt_kind_t RX_KIND_IN,
	input wire logic [5:0] RX_SRC_IN,
	input wire logic [5:0] RX_CYCLE_END_IN,
	input wire logic CYCLE_LOSS_IN,
	output logic TX_REQ_OUT,
	output cycle_resize_pkg::pkt_kind_t TX_KIND_OUT,
	output logic [5:0] TX_CYCLE_END_OUT,
	output logic PAYLOAD_ACCEPT_OUT,
	output logic OVERLAP_TRIG_OUT,
	output logic DONE_TRIG_OUT,
	output logic HALTED_TRIG_OUT
);
	import cycle_resize_pkg::*;

	localparam logic [6:0] ST_MAX = 7'h7F;
	localparam logic [31:0] NODE_CFG_INIT = `NODE_CFG_RESET;

	phase_t phase_r;
	logic [5:0] cycle_end_index_r;
	logic [5:0] pending_cycle_end_r;
	logic [2:0] sent_cnt_r;
	logic [6:0] slot_timer_r;
	logic [15:0] presc_r;
	logic [63:0] heard_peer_map_r;
	logic overlap_flag_r;
	logic halted_peer_seen_r;
	logic start_r;
	logic [5:0] node_id_r;
	logic [5:0] span_r;
	logic en_overlap_r;
	logic en_done_r;
	logic en_halted_r;
	logic [31:0] prdata_r;
	logic tx_req_r;
	pkt_kind_t tx_kind_r;
	logic [5:0] tx_fs_r;
	logic ovl_trig_r;
	logic done_trig_r;
	logic halt_trig_r;
	logic was_halted_r;

	logic wr_acc;
	logic rd_setup;
	logic mapped;
	logic slot_tick;
	logic [6:0] st_next;
	logic [6:0] own_last;
	logic rx_resize;
	logic peer_wins;
	logic ovl_event;
	logic peer_adopt;
	logic own_send;
	logic own_done;
	logic pend_wr_ok;
	logic ovl_clr;
	logic halt_clr;
	logic break_rx;
	logic sel_pending;
	logic sel_flags;
	logic sel_run_cfg;
	logic sel_node_cfg;
	logic span_short;
	logic break_exit;
	logic in_public;
	logic send_break;
	logic adopt_diff;

	assign wr_acc = PSEL_IN & PENABLE_IN & PWRITE_IN;
	assign rd_setup = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
	assign sel_pending = (PADDR_IN == `OFS_PENDING);
	assign sel_flags = (PADDR_IN == `OFS_EVENT_FLAGS);
	assign sel_run_cfg = (PADDR_IN == `OFS_RUN_CFG);
	assign sel_node_cfg = (PADDR_IN == `OFS_NODE_CFG);
	assign mapped = (PADDR_IN == `OFS_CYCLE_END) || (PADDR_IN == `OFS_PENDING) ||
		(PADDR_IN == `OFS_EVENT_FLAGS) || (PADDR_IN == `OFS_RUN_CFG) ||
		(PADDR_IN == `OFS_HEARD_LO) || (PADDR_IN == `OFS_HEARD_HI) ||
		(PADDR_IN == `OFS_NODE_CFG);
	// zero wait states: read data is captured in the setup cycle
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;
	assign PRDATA_OUT = prdata_r;

	// last slot of own span, widened so a large span cannot wrap
	assign own_last = {1'b0, node_id_r} + {1'b0, span_r} - 7'h01;

	// slot timing
	assign slot_tick = (presc_r == 16'(SLOT_CYCLES - 1));
	assign st_next = (slot_timer_r >= ({1'b0, cycle_end_index_r} + `PUBLIC_FRAMES)) ? 7'h00 :
		((slot_timer_r == ST_MAX) ? 7'h00 : slot_timer_r + 7'h01);

	// resize arbitration
	assign rx_resize = RX_VALID_IN && (RX_KIND_IN == PKT_RESIZE) && (RX_SRC_IN != node_id_r);
	assign peer_wins = RX_SRC_IN < node_id_r;
	assign ovl_event = rx_resize && (pending_cycle_end_r != 6'h00) && peer_wins;
	assign peer_adopt = rx_resize && ((pending_cycle_end_r == 6'h00) || peer_wins);
	assign own_send = slot_tick && (phase_r == PH_RUN) && (pending_cycle_end_r != 6'h00) &&
		(st_next == {1'b0, node_id_r}) && !ovl_event;
	assign own_done = own_send && (sent_cnt_r == (`RESIZE_REPEATS - 3'd1));
	assign pend_wr_ok = wr_acc && sel_pending && (phase_r == PH_RUN) &&
		(pending_cycle_end_r == 6'h00) && (PWDATA_IN[5:0] != 6'h00) &&
		({1'b0, PWDATA_IN[5:0]} >= own_last);
	assign adopt_diff = peer_adopt && (RX_CYCLE_END_IN != cycle_end_index_r);

	assign ovl_clr = wr_acc && sel_flags && PWDATA_IN[`BIT_OVERLAP];
	assign halt_clr = wr_acc && sel_flags && PWDATA_IN[`BIT_HALTED_SEEN];
	assign break_rx = RX_VALID_IN && (RX_KIND_IN == PKT_BREAK);

	// break while span is uncovered, or after a halt until a peer resize is adopted
	assign span_short = (own_last > {1'b0, cycle_end_index_r});
	assign break_exit = !span_short && !was_halted_r;
	assign in_public = (st_next > {1'b0, cycle_end_index_r});
	assign send_break = slot_tick && in_public &&
		((phase_r == PH_BREAK) || (was_halted_r && (phase_r == PH_IDLE) && start_r));

	// payload use only once running; before that packets only steer timing, maps, cycle end and the halted-peer flag
	assign PAYLOAD_ACCEPT_OUT = (phase_r == PH_RUN);
	assign TX_REQ_OUT = tx_req_r;
	assign TX_KIND_OUT = tx_kind_r;
	assign TX_CYCLE_END_OUT = tx_fs_r;
	assign OVERLAP_TRIG_OUT = ovl_trig_r;
	assign DONE_TRIG_OUT = done_trig_r;
	assign HALTED_TRIG_OUT = halt_trig_r;

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			presc_r <= 16'h0000;
			slot_timer_r <= 7'h00;
		end else if (RX_VALID_IN && (RX_KIND_IN == PKT_DATA)) begin
			// re-align to the sender's slot, even before start
			presc_r <= 16'h0000;
			slot_timer_r <= {1'b0, RX_SRC_IN};
		end else if (slot_tick) begin
			presc_r <= 16'h0000;
			slot_timer_r <= st_next;
		end else begin
			presc_r <= presc_r + 16'h0001;
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			heard_peer_map_r <= 64'h0000_0000_0000_0000;
		end else if (RX_VALID_IN && (RX_KIND_IN == PKT_DATA)) begin
			heard_peer_map_r[RX_SRC_IN] <= 1'b1;
		end else if (slot_tick && (st_next == 7'h00)) begin
			// map covers one cycle, so stale peers drop out each wrap
			heard_peer_map_r <= 64'h0000_0000_0000_0000;
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			cycle_end_index_r <= `CYCLE_END_RESET;
		end else if (own_done) begin
			cycle_end_index_r <= pending_cycle_end_r;
		end else if (peer_adopt) begin
			cycle_end_index_r <= RX_CYCLE_END_IN;
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			pending_cycle_end_r <= `PENDING_RESET;
			sent_cnt_r <= 3'd0;
		end else if (ovl_event || own_done || (phase_r != PH_RUN)) begin
			pending_cycle_end_r <= 6'h00;
			sent_cnt_r <= 3'd0;
		end else if (pend_wr_ok) begin
			pending_cycle_end_r <= PWDATA_IN[5:0];
			sent_cnt_r <= 3'd0;
		end else if (own_send) begin
			sent_cnt_r <= sent_cnt_r + 3'd1;
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			phase_r <= PH_IDLE;
		end else begin
			case (phase_r)
				PH_IDLE: begin
					if (start_r) begin
						phase_r <= (span_short || was_halted_r) ? PH_BREAK : PH_RUN;
					end
				end
				PH_RUN: begin
					if (!start_r) begin
						phase_r <= PH_IDLE;
					end else if (CYCLE_LOSS_IN) begin
						phase_r <= PH_HALT;
					end
				end
				PH_BREAK: begin
					if (!start_r) begin
						phase_r <= PH_IDLE;
					end else if (break_exit) begin
						phase_r <= PH_RUN;
					end
				end
				PH_HALT: begin
					// restart is signalled by software dropping and raising start
					if (!start_r) begin
						phase_r <= PH_IDLE;
					end
				end
				default: begin
					phase_r <= PH_IDLE;
				end
			endcase
		end
	end

	// a halt followed by restart always passes through break
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			was_halted_r <= 1'b0;
		end else if (phase_r == PH_HALT) begin
			was_halted_r <= 1'b1;
		end else if ((phase_r == PH_RUN) || (peer_adopt && (phase_r == PH_BREAK))) begin
			was_halted_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			tx_req_r <= 1'b0;
			tx_kind_r <= PKT_OTHER;
			tx_fs_r <= 6'h00;
		end else if (own_send) begin
			tx_req_r <= 1'b1;
			tx_kind_r <= PKT_RESIZE;
			tx_fs_r <= pending_cycle_end_r;
		end else if (send_break) begin
			tx_req_r <= 1'b1;
			tx_kind_r <= PKT_BREAK;
			tx_fs_r <= cycle_end_index_r;
		end else begin
			tx_req_r <= 1'b0;
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			overlap_flag_r <= 1'b0;
		end else begin
			// a new event in the clearing cycle keeps the flag set
			overlap_flag_r <= ovl_event | (overlap_flag_r & ~ovl_clr);
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			halted_peer_seen_r <= 1'b0;
		end else begin
			halted_peer_seen_r <= break_rx | (halted_peer_seen_r & ~halt_clr);
		end
	end

	// overlap and halted-peer triggers fire on the flag's rise only, so repeats stay one interrupt
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			ovl_trig_r <= 1'b0;
		end else begin
			ovl_trig_r <= en_overlap_r & ovl_event & ~overlap_flag_r;
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			done_trig_r <= 1'b0;
		end else begin
			done_trig_r <= en_done_r & (ovl_event | own_done | adopt_diff);
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			halt_trig_r <= 1'b0;
		end else begin
			halt_trig_r <= en_halted_r & break_rx & ~halted_peer_seen_r;
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			start_r <= 1'b0;
		end else if (wr_acc && sel_run_cfg) begin
			start_r <= PWDATA_IN[`BIT_START];
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			node_id_r <= NODE_CFG_INIT[5:0];
			span_r <= NODE_CFG_INIT[13:8];
			en_overlap_r <= 1'b0;
			en_done_r <= 1'b0;
			en_halted_r <= 1'b0;
		end else if (wr_acc && sel_node_cfg && (phase_r == PH_IDLE)) begin
			// identity may only change while stopped
			node_id_r <= PWDATA_IN[5:0];
			span_r <= (PWDATA_IN[13:8] == 6'h00) ? 6'h01 : PWDATA_IN[13:8];
			en_overlap_r <= PWDATA_IN[`BIT_EN_OVERLAP];
			en_done_r <= PWDATA_IN[`BIT_EN_DONE];
			en_halted_r <= PWDATA_IN[`BIT_EN_HALTED];
		end else if (wr_acc && sel_node_cfg) begin
			en_overlap_r <= PWDATA_IN[`BIT_EN_OVERLAP];
			en_done_r <= PWDATA_IN[`BIT_EN_DONE];
			en_halted_r <= PWDATA_IN[`BIT_EN_HALTED];
		end
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			prdata_r <= 32'h0000_0000;
		end else if (rd_setup) begin
			case (PADDR_IN)
				`OFS_CYCLE_END: prdata_r <= {26'h000_0000, cycle_end_index_r};
				`OFS_PENDING: prdata_r <= {26'h000_0000, pending_cycle_end_r};
				`OFS_EVENT_FLAGS: prdata_r <= {21'h00_0000, halted_peer_seen_r, 1'b0, overlap_flag_r,
					8'h00};
				`OFS_RUN_CFG: prdata_r <= {22'h00_0000, (phase_r == PH_RUN), start_r, 1'b0,
					slot_timer_r};
				`OFS_HEARD_LO: prdata_r <= heard_peer_map_r[31:0];
				`OFS_HEARD_HI: prdata_r <= heard_peer_map_r[63:32];
				`OFS_NODE_CFG: prdata_r <= {13'h0000, en_halted_r, en_done_r, en_overlap_r, 2'b00,
					span_r, 2'b00, node_id_r};
				default: prdata_r <= 32'h0000_0000;
			endcase
		end
	end
endmodule

// ---- rtl/cycle_resize_params.svh ----
`ifndef CYCLE_RESIZE_PARAMS_SVH
`define CYCLE_RESIZE_PARAMS_SVH

`define OFS_CYCLE_END 12'h000
`define OFS_PENDING 12'h004
`define OFS_EVENT_FLAGS 12'h008
`define OFS_RUN_CFG 12'h00C
`define OFS_HEARD_LO 12'h010
`define OFS_HEARD_HI 12'h014
`define OFS_NODE_CFG 12'h018

`define CYCLE_END_RESET 6'h3F
`define PENDING_RESET 6'h00
`define NODE_CFG_RESET 32'h0000_0100

`define BIT_OVERLAP 8
`define BIT_HALTED_SEEN 10
`define BIT_START 8
`define BIT_RUNNING 9
`define BIT_EN_OVERLAP 16
`define BIT_EN_DONE 17
`define BIT_EN_HALTED 18

`define RESIZE_REPEATS 3'd4
`define PUBLIC_FRAMES 7'h02

`endif

// ---- rtl/cycle_resize_pkg.sv ----
package cycle_resize_pkg;
	typedef enum logic [3:0] {
		PH_IDLE = 4'b0001,
		PH_RUN = 4'b0010,
		PH_BREAK = 4'b0100,
		PH_HALT = 4'b1000
	} phase_t;

	typedef enum logic [1:0] {
		PKT_DATA = 2'b00,
		PKT_RESIZE = 2'b01,
		PKT_BREAK = 2'b10,
		PKT_OTHER = 2'b11
	} pkt_kind_t;
endpackage

// ---- test/cycle_resize_manager_sva.sv ----
`timescale 1ns/1ps
`include "cycle_resize_params.svh"
module cycle_resize_sva (
	input wire logic CLK_IN,
	input wire logic NRST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic RX_VALID_IN,
	input wire cycle_resize_pkg::pkt_kind_t RX_KIND_IN,
	input wire logic TX_REQ_OUT,
	input wire cycle_resize_pkg::pkt_kind_t TX_KIND_OUT,
	input wire logic PAYLOAD_ACCEPT_OUT,
	input wire logic OVERLAP_TRIG_OUT,
	input wire logic DONE_TRIG_OUT,
	input wire logic HALTED_TRIG_OUT
);
	import cycle_resize_pkg::*;
	logic wr;
	logic ovl_arm_r;
	logic hlt_arm_r;
	logic en_done_r;
	assign wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
	// a trigger is allowed again only once software has cleared the flag
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			ovl_arm_r <= 1'b1;
			hlt_arm_r <= 1'b1;
			en_done_r <= 1'b0;
		end else begin
			if (wr && PADDR_IN == `OFS_EVENT_FLAGS && PWDATA_IN[`BIT_OVERLAP])
				ovl_arm_r <= 1'b1;
			else if (OVERLAP_TRIG_OUT)
				ovl_arm_r <= 1'b0;
			if (wr && PADDR_IN == `OFS_EVENT_FLAGS && PWDATA_IN[`BIT_HALTED_SEEN])
				hlt_arm_r <= 1'b1;
			else if (HALTED_TRIG_OUT)
				hlt_arm_r <= 1'b0;
			if (wr && PADDR_IN == `OFS_NODE_CFG)
				en_done_r <= PWDATA_IN[`BIT_EN_DONE];
		end
	end
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!NRST_IN);
	property p_hlt_cause; HALTED_TRIG_OUT |-> $past(RX_VALID_IN) && $past(RX_KIND_IN) == PKT_BREAK; endproperty
	a_hlt_cause: assert property (p_hlt_cause) else $error("halted trigger without break");
	property p_hlt_once; HALTED_TRIG_OUT |-> hlt_arm_r; endproperty
	a_hlt_once: assert property (p_hlt_once) else $error("halted trigger while flag set");
	property p_ovl_cause; OVERLAP_TRIG_OUT |-> $past(RX_VALID_IN) && $past(RX_KIND_IN) == PKT_RESIZE; endproperty
	a_ovl_cause: assert property (p_ovl_cause) else $error("overlap trigger without resize");
	property p_ovl_once; OVERLAP_TRIG_OUT |-> ovl_arm_r; endproperty
	a_ovl_once: assert property (p_ovl_once) else $error("overlap trigger while flag set");
	property p_ovl_done; OVERLAP_TRIG_OUT && en_done_r |-> DONE_TRIG_OUT; endproperty
	a_ovl_done: assert property (p_ovl_done) else $error("overlap without done trigger");
	// tx is registered, so the phase is judged one edge back
	property p_rsz_run; TX_REQ_OUT && TX_KIND_OUT == PKT_RESIZE |-> $past(PAYLOAD_ACCEPT_OUT); endproperty
	a_rsz_run: assert property (p_rsz_run) else $error("resize sent outside run");
	property p_brk_idle; TX_REQ_OUT && TX_KIND_OUT == PKT_BREAK |-> !$past(PAYLOAD_ACCEPT_OUT); endproperty
	a_brk_idle: assert property (p_brk_idle) else $error("break sent while running");
	property p_pend_lock;
		wr && PADDR_IN == `OFS_PENDING && !PAYLOAD_ACCEPT_OUT ##[1:2] PSEL_IN && !PENABLE_IN && !PWRITE_IN
			&& PADDR_IN == `OFS_PENDING |=> PRDATA_OUT[5:0] == 6'h00;
	endproperty
	a_pend_lock: assert property (p_pend_lock) else $error("pending written outside run");
	c_ovl: cover property (OVERLAP_TRIG_OUT && DONE_TRIG_OUT);
	c_hlt: cover property (HALTED_TRIG_OUT);
	c_rsz: cover property (TX_REQ_OUT && TX_KIND_OUT == PKT_RESIZE);
endmodule
bind cycle_resize_manager cycle_resize_sva cycle_resize_sva_i (.CLK_IN, .NRST_IN, .PSEL_IN, .PENABLE_IN,
	.PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PRDATA_OUT, .RX_VALID_IN, .RX_KIND_IN, .TX_REQ_OUT, .TX_KIND_OUT,
	.PAYLOAD_ACCEPT_OUT, .OVERLAP_TRIG_OUT, .DONE_TRIG_OUT, .HALTED_TRIG_OUT);

// ---- test/peer_station.sv ----
`timescale 1ns/1ps
module peer_station (
	input wire logic clk_in,
	input wire logic tx_req_in,
	input wire cycle_resize_pkg::pkt_kind_t tx_kind_in,
	output logic rx_valid_out,
	output cycle_resize_pkg::pkt_kind_t rx_kind_out,
	output logic [5:0] rx_src_out,
	output logic [5:0] rx_fs_out,
	output logic [7:0] n_rsz_out,
	output logic [7:0] n_brk_out
);
	import cycle_resize_pkg::*;
	initial begin
		rx_valid_out = 1'b0;
		rx_kind_out = PKT_OTHER;
		rx_src_out = 6'h00;
		rx_fs_out = 6'h00;
		n_rsz_out = 8'h00;
		n_brk_out = 8'h00;
	end
	// one packet per call; fields inverted after so nothing stale looks valid
	task automatic send(input pkt_kind_t k, input logic [5:0] s, input logic [5:0] f);
		@(posedge clk_in);
		rx_valid_out <= 1'b1;
		rx_kind_out <= k;
		rx_src_out <= s;
		rx_fs_out <= f;
		@(posedge clk_in);
		rx_valid_out <= 1'b0;
		rx_kind_out <= PKT_OTHER;
		rx_src_out <= ~s;
		rx_fs_out <= ~f;
	endtask
	always @(posedge clk_in) begin
		if (tx_req_in && tx_kind_in == PKT_RESIZE)
			n_rsz_out <= n_rsz_out + 8'h01;
		if (tx_req_in && tx_kind_in == PKT_BREAK)
			n_brk_out <= n_brk_out + 8'h01;
	end
endmodule

// ---- test/tb_cycle_resize_manager.sv ----
`timescale 1ns/1ps
`include "cycle_resize_params.svh"
module tb_cycle_resize_manager;
	import cycle_resize_pkg::*;
	logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, rdy, serr, serr_q, txq, acc, ovt, dnt, hlt, rxv;
	logic loss = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic [5:0] rxs, rxf, txf;
	logic [7:0] nrsz, nbrk;
	pkt_kind_t rxk, txk;
	int errors = 0, n_tests = 0, n_ovl = 0, n_done = 0, n_hlt = 0, cyc = 0;
	cycle_resize_manager #(.SLOT_CYCLES(4)) cycle_resize_manager_i (.CLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(rdy), .PSLVERR_OUT(serr), .RX_VALID_IN(rxv), .RX_KIND_IN(rxk), .RX_SRC_IN(rxs),
		.RX_CYCLE_END_IN(rxf), .CYCLE_LOSS_IN(loss), .TX_REQ_OUT(txq), .TX_KIND_OUT(txk), .TX_CYCLE_END_OUT(txf),
		.PAYLOAD_ACCEPT_OUT(acc), .OVERLAP_TRIG_OUT(ovt), .DONE_TRIG_OUT(dnt), .HALTED_TRIG_OUT(hlt));
	peer_station peer_station_i (.clk_in(clk), .tx_req_in(txq), .tx_kind_in(txk), .rx_valid_out(rxv),
		.rx_kind_out(rxk), .rx_src_out(rxs), .rx_fs_out(rxf), .n_rsz_out(nrsz), .n_brk_out(nbrk));
	initial forever #20 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (ovt === 1'b1) n_ovl <= n_ovl + 1;
		if (dnt === 1'b1) n_done <= n_done + 1;
		if (hlt === 1'b1) n_hlt <= n_hlt + 1;
		if (cyc == 6000) begin
			errors++;
			test_done();
		end
	end
	task automatic test_done;
		$display("errors %0d n_tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (rdy !== 1'b1) @(posedge clk);
		q = prdata;
		serr_q = serr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h0000_0000);
		chk(n, e, q);
	endtask
	task automatic t_idle;
		logic [6:0] t;
		rd(`OFS_CYCLE_END, 32'h0000_003F, "cycle end");
		rd(`OFS_EVENT_FLAGS, 32'h0000_0000, "flags");
		rd(12'h01C, 32'h0000_0000, "unmapped");
		chk("slverr", 32'h0000_0001, serr_q);
		chk("accept", 32'h0000_0000, acc);
		apb(1'b1, `OFS_NODE_CFG, 32'h0007_0502);
		apb(1'b1, `OFS_PENDING, 32'h0000_003A);
		rd(`OFS_PENDING, 32'h0000_0000, "pending");
		t = q[6:0];
		apb(1'b0, `OFS_RUN_CFG, 32'h0000_0000);
		t = q[6:0];
		repeat (8) @(posedge clk);
		apb(1'b0, `OFS_RUN_CFG, 32'h0000_0000);
		chk("slot timer", 32'h0000_0001, q[6:0] != t);
		peer_station_i.send(PKT_DATA, 6'h05, 6'h00);
		apb(1'b0, `OFS_HEARD_LO, 32'h0000_0000);
		chk("heard", 32'h0000_0020, q & 32'h0000_0020);
		peer_station_i.send(PKT_RESIZE, 6'h03, 6'h04);
		rd(`OFS_CYCLE_END, 32'h0000_0004, "adopt");
		chk("done trig", 32'h0000_0001, n_done);
	endtask
	task automatic t_break;
		apb(1'b1, `OFS_RUN_CFG, 32'h0000_0100);
		apb(1'b0, `OFS_RUN_CFG, 32'h0000_0000);
		chk("running", 32'h0000_0000, q[`BIT_RUNNING]);
		for (int i = 0; i < 200 && nbrk == 0; i++) @(posedge clk);
		chk("break tx", 32'h0000_0001, nbrk != 0);
		chk("accept", 32'h0000_0000, acc);
		peer_station_i.send(PKT_RESIZE, 6'h01, 6'h3F);
		apb(1'b0, `OFS_RUN_CFG, 32'h0000_0000);
		chk("running", 32'h0000_0001, q[`BIT_RUNNING]);
	endtask
	task automatic t_resize;
		logic [7:0] n;
		int d;
		chk("accept run", 32'h0000_0001, acc);
		apb(1'b1, `OFS_PENDING, 32'h0000_0005);
		rd(`OFS_PENDING, 32'h0000_0000, "reject");
		n = nrsz;
		d = n_done;
		apb(1'b1, `OFS_PENDING, 32'h0000_0006);
		rd(`OFS_PENDING, 32'h0000_0006, "accept");
		for (int i = 0; i < 1500 && q != 0; i++) apb(1'b0, `OFS_PENDING, 32'h0000_0000);
		chk("sends", 32'h0000_0004, nrsz - n);
		chk("tx value", 32'h0000_0006, txf);
		rd(`OFS_CYCLE_END, 32'h0000_0006, "new end");
		rd(`OFS_EVENT_FLAGS, 32'h0000_0000, "flags");
		chk("done", 32'h0000_0001, n_done - d);
	endtask
	task automatic t_overlap;
		int d;
		d = n_done;
		apb(1'b1, `OFS_PENDING, 32'h0000_0020);
		peer_station_i.send(PKT_RESIZE, 6'h04, 6'h10);
		rd(`OFS_CYCLE_END, 32'h0000_0006, "low wins");
		peer_station_i.send(PKT_RESIZE, 6'h01, 6'h28);
		rd(`OFS_CYCLE_END, 32'h0000_0028, "high");
		rd(`OFS_EVENT_FLAGS, 32'h0000_0100, "overlap");
		chk("ovl trig", 32'h0000_0001, n_ovl);
		chk("ovl done", 32'h0000_0001, n_done - d);
		apb(1'b1, `OFS_PENDING, 32'h0000_0020);
		peer_station_i.send(PKT_RESIZE, 6'h01, 6'h30);
		apb(1'b1, `OFS_EVENT_FLAGS, 32'h0000_0000);
		rd(`OFS_EVENT_FLAGS, 32'h0000_0100, "w0 keeps");
		chk("ovl again", 32'h0000_0001, n_ovl);
		apb(1'b1, `OFS_EVENT_FLAGS, 32'h0000_0100);
		rd(`OFS_EVENT_FLAGS, 32'h0000_0000, "w1 clears");
	endtask
	task automatic t_halt;
		peer_station_i.send(PKT_BREAK, 6'h09, 6'h00);
		rd(`OFS_EVENT_FLAGS, 32'h0000_0400, "halted");
		peer_station_i.send(PKT_BREAK, 6'h09, 6'h00);
		rd(`OFS_EVENT_FLAGS, 32'h0000_0400, "halted");
		chk("hlt trig", 32'h0000_0001, n_hlt);
		apb(1'b1, `OFS_EVENT_FLAGS, 32'h0000_0400);
		rd(`OFS_EVENT_FLAGS, 32'h0000_0000, "cleared");
		peer_station_i.send(PKT_BREAK, 6'h09, 6'h00);
		rd(`OFS_EVENT_FLAGS, 32'h0000_0400, "set again");
		chk("hlt trig", 32'h0000_0002, n_hlt);
	endtask
	task automatic t_loss;
		logic [7:0] b;
		b = nbrk;
		@(posedge clk);
		loss <= 1'b1;
		@(posedge clk);
		loss <= 1'b0;
		apb(1'b0, `OFS_RUN_CFG, 32'h0000_0000);
		chk("halted", 32'h0000_0000, q[`BIT_RUNNING]);
		apb(1'b1, `OFS_RUN_CFG, 32'h0000_0000);
		apb(1'b1, `OFS_RUN_CFG, 32'h0000_0100);
		for (int i = 0; i < 300 && nbrk == b; i++) @(posedge clk);
		chk("restart break", 32'h0000_0001, nbrk != b);
		peer_station_i.send(PKT_RESIZE, 6'h01, 6'h3F);
		apb(1'b0, `OFS_RUN_CFG, 32'h0000_0000);
		chk("rejoined", 32'h0000_0001, q[`BIT_RUNNING]);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		t_idle();
		t_break();
		t_resize();
		t_overlap();
		t_halt();
		t_loss();
		test_done();
	end
endmodule
